// File: verilog/mpw_params.svh
`ifndef MPW_PARAMS_SVH
`define MPW_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define MPW_OFS_STATUS 8'h00
`define MPW_OFS_CTRL 8'h04
`define MPW_OFS_COUNT 8'h08
`define MPW_OFS_PRESCALE 8'h0c
`define MPW_OFS_PRECOUNT 8'h10
`define MPW_OFS_MATCHCTL 8'h14
`define MPW_OFS_MATCH0 8'h18
`define MPW_OFS_MATCH6 8'h30
`define MPW_OFS_OUTCFG 8'h34
`define MPW_OFS_LATCH 8'h38
`define MPW_OFS_MASK 8'h3c

////////////////////////////////////////////////////////////////////////////
// Field positions
`define MPW_CTRL_RUN 0
`define MPW_CTRL_CLR 1
`define MPW_CTRL_PWM 3
`define MPW_MC_INT 0
`define MPW_MC_RST 1
`define MPW_MC_STOP 2
`define MPW_MC_WIDTH 3
`define MPW_CFG_EN 8

////////////////////////////////////////////////////////////////////////////
// Sizes and reset values
`define MPW_NMATCH 7
`define MPW_NOUT 6
`define MPW_RST_WORD 32'h0000_0000

`endif

// File: verilog/mpw_pkg.sv
`default_nettype none
`include "mpw_params.svh"

package mpw_pkg;

  typedef logic [31:0] mpw_word_t;
  typedef logic [`MPW_NMATCH-1:0] mpw_mask_t;
  typedef logic [`MPW_NMATCH-1:0][31:0] mpw_bank_t;

  // Byte-lane merge of a bus write into a stored word
  function automatic mpw_word_t mpw_merge(input mpw_word_t old_w,
                                          input mpw_word_t new_w,
                                          input logic [3:0] sel);
    mpw_word_t r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction : mpw_merge

endpackage : mpw_pkg

`default_nettype wire

// File: verilog/mpw_match_bank.sv
`timescale 1ns/10ps
`default_nettype none

module mpw_match_bank
  import mpw_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Software write port
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [3:0] wr_sel,
  input wire mpw_word_t wr_data,
  input wire logic direct,
  // Release of shadow words into the comparators
  input wire mpw_mask_t xfer,
  // Read port and comparator values
  input wire logic [2:0] rd_idx,
  output mpw_word_t rd_data,
  output mpw_bank_t active
);

  mpw_bank_t shadow;

  ////////////////////////////////////////////////////////////////////////////
  // One shadow and one active word per match channel
  for (genvar i = 0; i < `MPW_NMATCH; i++) begin : g_word
    mpw_word_t sh;
    mpw_word_t ac;
    logic sel_me;
    assign sel_me = wr_en && (wr_idx == 3'(i));
    assign shadow[i] = sh;
    assign active[i] = ac;
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        sh <= `MPW_RST_WORD;
        ac <= `MPW_RST_WORD;
      end else if (ce) begin
        if (sel_me) begin
          sh <= mpw_merge(sh, wr_data, wr_sel);
        end
        // Plain timer mode bypasses the release step
        if (sel_me && direct) begin
          ac <= mpw_merge(sh, wr_data, wr_sel);
        end else if (xfer[i]) begin
          ac <= sh;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read of the software view
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_data <= `MPW_RST_WORD;
    end else if (ce) begin
      rd_data <= (rd_idx < 3'(`MPW_NMATCH)) ? shadow[rd_idx] : `MPW_RST_WORD;
    end
  end

endmodule : mpw_match_bank

`default_nettype wire

// File: verilog/mpw_unit.sv
`timescale 1ns/10ps
`default_nettype none

module mpw_unit
  import mpw_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Waveforms and interrupt
  output logic [`MPW_NOUT:1] pwm_out,
  output logic irq
);

  localparam logic [5:0] W_BANK_LO = 6'(`MPW_OFS_MATCH0 >> 2);
  localparam logic [5:0] W_BANK_HI = 6'(`MPW_OFS_MATCH6 >> 2);
  localparam int MCW = `MPW_NMATCH * `MPW_MC_WIDTH;

  // Word decode shared by read and write paths
  function automatic logic is_reg(input logic [7:0] adr,
                                  input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : is_reg

  logic req, ph, wr_now, in_bank;
  logic [5:0] widx, bidx;
  mpw_word_t rd_mux, bank_rd, pr, pc, tc, next_tc;
  mpw_bank_t act;
  logic run, clr_hold, pwm_en, tick, any_rst, any_stop;
  logic [MCW-1:0] mcr;
  mpw_mask_t ir, imr, ler, dbl, oen, hit;
  mpw_mask_t rst_mask, stop_mask, int_mask, xfer;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: decode cycle, answer cycle, write at the ack edge
  assign req = cyc_i && stb_i;
  assign wr_now = req && we_i && ack_o;
  assign widx = adr_i[7:2];
  assign in_bank = (widx >= W_BANK_LO) && (widx <= W_BANK_HI);
  assign bidx = widx - W_BANK_LO;

  // Extra decode cycle lets the bank's registered read settle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ph <= 1'b0;
      ack_o <= 1'b0;
    end else if (ce) begin
      ph <= req && !ph && !ack_o;
      ack_o <= ph && req;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    rd_mux = `MPW_RST_WORD;
    if (in_bank) begin
      rd_mux = bank_rd;
    end else if (is_reg(adr_i, `MPW_OFS_STATUS)) begin
      rd_mux = 32'(ir);
    end else if (is_reg(adr_i, `MPW_OFS_CTRL)) begin
      rd_mux[`MPW_CTRL_RUN] = run;
      rd_mux[`MPW_CTRL_CLR] = clr_hold;
      rd_mux[`MPW_CTRL_PWM] = pwm_en;
    end else if (is_reg(adr_i, `MPW_OFS_COUNT)) begin
      rd_mux = tc;
    end else if (is_reg(adr_i, `MPW_OFS_PRESCALE)) begin
      rd_mux = pr;
    end else if (is_reg(adr_i, `MPW_OFS_PRECOUNT)) begin
      rd_mux = pc;
    end else if (is_reg(adr_i, `MPW_OFS_MATCHCTL)) begin
      rd_mux = 32'(mcr);
    end else if (is_reg(adr_i, `MPW_OFS_OUTCFG)) begin
      rd_mux = 32'(dbl);
      rd_mux[`MPW_CFG_EN +: `MPW_NMATCH] = oen;
    end else if (is_reg(adr_i, `MPW_OFS_LATCH)) begin
      rd_mux = 32'(ler);
    end else if (is_reg(adr_i, `MPW_OFS_MASK)) begin
      rd_mux = 32'(imr);
    end
  end

  // Read data captured as ack rises
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dat_o <= `MPW_RST_WORD;
    end else if (ce && ph && req) begin
      dat_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match value storage: shadow for software, active for comparators
  mpw_match_bank u_bank (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .wr_en(wr_now && in_bank),
    .wr_idx(bidx[2:0]),
    .wr_sel(sel_i),
    .wr_data(dat_i),
    .direct(!pwm_en),
    .xfer(xfer),
    .rd_idx(bidx[2:0]),
    .rd_data(bank_rd),
    .active(act)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pr <= `MPW_RST_WORD;
      mcr <= '0;
      imr <= '0;
      dbl <= '0;
      oen <= '0;
    end else if (ce && wr_now) begin
      if (is_reg(adr_i, `MPW_OFS_PRESCALE)) begin
        pr <= mpw_merge(pr, dat_i, sel_i);
      end
      if (is_reg(adr_i, `MPW_OFS_MATCHCTL)) begin
        mcr <= MCW'(mpw_merge(32'(mcr), dat_i, sel_i));
      end
      if (is_reg(adr_i, `MPW_OFS_MASK)) begin
        imr <= mpw_mask_t'(mpw_merge(32'(imr), dat_i, sel_i));
      end
      if (is_reg(adr_i, `MPW_OFS_OUTCFG)) begin
        dbl <= mpw_mask_t'(dat_i);
        oen <= dat_i[`MPW_CFG_EN +: `MPW_NMATCH];
      end
    end
  end

  // Control word; a software write beats a same-cycle stop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      run <= 1'b0;
      clr_hold <= 1'b0;
      pwm_en <= 1'b0;
    end else if (ce) begin
      if (wr_now && is_reg(adr_i, `MPW_OFS_CTRL) && sel_i[0]) begin
        run <= dat_i[`MPW_CTRL_RUN];
        clr_hold <= dat_i[`MPW_CTRL_CLR];
        pwm_en <= dat_i[`MPW_CTRL_PWM];
      end else if (any_stop) begin
        run <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match detection; compares use full 32 bits, so any count is legal
  for (genvar i = 0; i < `MPW_NMATCH; i++) begin : g_match
    assign hit[i] = tick && (tc == act[i]);
    assign int_mask[i] = mcr[`MPW_MC_WIDTH*i + `MPW_MC_INT];
    assign stop_mask[i] = mcr[`MPW_MC_WIDTH*i + `MPW_MC_STOP];
    if (i == 0) begin : g_period
      // PWM mode forces the period reset so every output shares one rate
      assign rst_mask[i] = mcr[`MPW_MC_RST] || pwm_en;
    end else begin : g_other
      assign rst_mask[i] = mcr[`MPW_MC_WIDTH*i + `MPW_MC_RST];
    end
  end

  assign any_rst = |(hit & rst_mask);
  assign any_stop = |(hit & stop_mask);
  assign tick = run && !clr_hold && (pc == pr);
  assign next_tc = any_rst ? `MPW_RST_WORD : tc + 32'h0000_0001;

  ////////////////////////////////////////////////////////////////////////////
  // Prescale and timer counters
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pc <= `MPW_RST_WORD;
    end else if (ce) begin
      if (clr_hold || tick) begin
        pc <= `MPW_RST_WORD;
      end else if (run) begin
        pc <= pc + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tc <= `MPW_RST_WORD;
    end else if (ce) begin
      if (wr_now && is_reg(adr_i, `MPW_OFS_COUNT)) begin
        tc <= mpw_merge(tc, dat_i, sel_i);
      end else if (clr_hold) begin
        tc <= `MPW_RST_WORD;
      end else if (tick) begin
        tc <= next_tc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Release: software marks words, the period match moves them
  assign xfer = (pwm_en && hit[0]) ? ler : '0;

  // Software write replaces the mask, winning over the hardware clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ler <= '0;
    end else if (ce) begin
      if (wr_now && is_reg(adr_i, `MPW_OFS_LATCH) && sel_i[0]) begin
        ler <= mpw_mask_t'(dat_i);
      end else begin
        ler <= ler & ~xfer;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky match flags, write one to clear; a new match wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ir <= '0;
    end else if (ce) begin
      if (wr_now && is_reg(adr_i, `MPW_OFS_STATUS) && sel_i[0]) begin
        ir <= (ir & ~mpw_mask_t'(dat_i)) | (hit & int_mask);
      end else begin
        ir <= ir | (hit & int_mask);
      end
    end
  end

  assign irq = |(ir & imr);

  ////////////////////////////////////////////////////////////////////////////
  // Output waveforms; output 1 has no lower match so it is single only
  for (genvar n = 1; n <= `MPW_NOUT; n++) begin : g_out
    logic is_dbl;
    logic set_ev;
    logic clr_ev;
    logic const_lo;
    assign is_dbl = (n >= 2) && dbl[n];
    assign set_ev = is_dbl ? hit[n-1] : hit[0];
    assign clr_ev = hit[n];
    // A zero edge word in single mode means a constant low output
    assign const_lo = !is_dbl && (act[n] == `MPW_RST_WORD);
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        pwm_out[n] <= 1'b0;
      end else if (ce) begin
        if (!pwm_en || !oen[n] || const_lo) begin
          pwm_out[n] <= 1'b0;
        end else if (clr_ev) begin
          pwm_out[n] <= 1'b0;
        end else if (set_ev) begin
          pwm_out[n] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_count_step;
    ce && tick && !any_rst && !clr_hold && !wr_now
      |=> tc == $past(tc) + 32'h0000_0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance on prescale tick");
  property p_period_reset;
    ce && pwm_en && hit[0] && !wr_now |=> tc == `MPW_RST_WORD;
  endproperty
  a_period_reset: assert property (p_period_reset)
    else $error("period match did not clear the counter");
  property p_single_rise;
    ce && pwm_en && oen[1] && hit[0] && !hit[1] && act[1] != 32'h0
      && !wr_now |=> pwm_out[1];
  endproperty
  a_single_rise: assert property (p_single_rise)
    else $error("single edge output did not rise at period start");
  property p_single_fall;
    ce && hit[1] |=> !pwm_out[1];
  endproperty
  a_single_fall: assert property (p_single_fall)
    else $error("single edge output did not fall at its match");
  property p_double_rise;
    ce && pwm_en && oen[2] && dbl[2] && hit[1] && !hit[2] && !wr_now
      |=> pwm_out[2] ##1 (pwm_out[2] || $past(hit[2]) || !$past(ce)
      || $past(wr_now));
  endproperty
  a_double_rise: assert property (p_double_rise)
    else $error("double edge output missed its rising match");
  property p_mix_six;
    ce && pwm_en && oen[6] && dbl[6] && hit[5] && !hit[6] && !wr_now
      |=> pwm_out[6];
  endproperty
  a_mix_six: assert property (p_mix_six)
    else $error("sixth output ignored its double edge pair");
  property p_stop;
    ce && |(hit & stop_mask) && !wr_now |=> !run;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop on match left the counter running");
  property p_flag;
    ce && |(hit & int_mask) |=> (ir & $past(hit & int_mask))
      == $past(hit & int_mask);
  endproperty
  a_flag: assert property (p_flag)
    else $error("match flag lost");
  property p_hold_active;
    ce && pwm_en && !hit[0] && !wr_now |=> act == $past(act);
  endproperty
  a_hold_active: assert property (p_hold_active)
    else $error("comparator changed outside the period match");
  property p_width_any;
    ce && hit[3] |=> !pwm_out[3];
  endproperty
  a_width_any: assert property (p_width_any)
    else $error("output edge missed at its exact count");
  property p_timer_mode;
    ce && !pwm_en |=> pwm_out == '0;
  endproperty
  a_timer_mode: assert property (p_timer_mode)
    else $error("waveform driven outside PWM mode");
  property p_release;
    ce && pwm_en && hit[0] && !wr_now |=> ler == '0;
  endproperty
  a_release: assert property (p_release)
    else $error("release mask not consumed at period match");
  property p_freeze;
    !ce |=> pwm_out == $past(pwm_out) && tc == $past(tc);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while the clock enable was low");

  c_period: cover property (ce && pwm_en && hit[0] && |ler);
  c_stop: cover property (ce && |(hit & stop_mask));
  c_double: cover property (pwm_en && dbl[2] && pwm_out[2]);
  c_irq: cover property (!irq ##1 irq);

endmodule : mpw_unit

`default_nettype wire

// File: verification/test_match_based_pwm_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "mpw_params.svh"

module test_match_based_pwm_unit
  import mpw_pkg::*;
  ;

  typedef struct {
    logic [7:0] a;
    mpw_word_t w;
    mpw_word_t e;
  } mpw_row_t;

  // Bus and waveform nets
  logic mclk;
  logic reset;
  logic ce;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  mpw_word_t dat_w;
  mpw_word_t dat_r;
  logic ack;
  logic [`MPW_NOUT:1] pwm;
  logic [`MPW_NOUT:1] acc;
  logic irq;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int hi;
  int per;
  int k;
  mpw_word_t rd;
  mpw_word_t mv [7] = '{32'h9, 32'h3, 32'h7, 32'h2, 32'h1, 32'h7, 32'h0};
  // Ordinary register cases: address, write value, read-back value
  mpw_row_t rows [9] = '{
    '{`MPW_OFS_PRESCALE, 32'hffff_ffff, 32'hffff_ffff},
    '{`MPW_OFS_COUNT, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{`MPW_OFS_MATCH0, 32'h1234_5678, 32'h1234_5678},
    '{`MPW_OFS_MATCH6, 32'h8000_0001, 32'h8000_0001},
    '{`MPW_OFS_MATCHCTL, 32'hffff_ffff, 32'h001f_ffff},
    '{`MPW_OFS_MASK, 32'hffff_ffff, 32'h0000_007f},
    '{`MPW_OFS_PRECOUNT, 32'h0000_0005, 32'h0000_0000},
    '{8'h40, 32'hffff_ffff, 32'h0000_0000},
    '{`MPW_OFS_STATUS, 32'h0000_00ff, 32'h0000_0000}};

  mpw_unit u_mpw_unit (
    .mclk(mclk), .reset(reset), .ce(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r),
    .ack_o(ack), .pwm_out(pwm), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Generous ceiling, the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input mpw_word_t seen, input mpw_word_t exp, input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask : chk

  task test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Classic cycle: hold everything until ack is sampled, then release
  task wb(input logic w, input logic [7:0] a, input mpw_word_t d,
          output mpw_word_t q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_r;
    if (n >= 50) chk(32'h0, 32'h1, "no bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task wr(input logic [7:0] a, input mpw_word_t d);
    mpw_word_t q;
    wb(1'b1, a, d, q);
  endtask : wr

  task rdc(input logic [7:0] a, input mpw_word_t e, input string what);
    wb(1'b0, a, 32'h0, rd);
    chk(rd, e, what);
  endtask : rdc

  // Cycles high and full period, starting at a rising edge of output n
  task meas(input int n, output int h, output int p);
    int j;
    j = 0;
    h = 0;
    while (pwm[n] !== 1'b0 && j < 500) begin
      @(posedge mclk);
      j++;
    end
    while (pwm[n] !== 1'b1 && j < 500) begin
      @(posedge mclk);
      j++;
    end
    while (pwm[n] === 1'b1 && j < 500) begin
      @(posedge mclk);
      j++;
      h++;
    end
    p = h;
    while (pwm[n] !== 1'b1 && j < 500) begin
      @(posedge mclk);
      j++;
      p++;
    end
    if (j >= 500) chk(32'h0, 32'h1, "waveform missing");
  endtask : meas

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i]) rdc(rows[i].a, `MPW_RST_WORD, "reset value");
    chk(32'(pwm), 32'h0, "outputs after reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e, "read back");
    end
    $display("test registers done");
    // Second reset clears the table contents
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    // Period 10 counts, each count 2 clocks; values go straight in
    wr(`MPW_OFS_PRESCALE, 32'h1);
    for (int i = 0; i < 7; i++) wr(`MPW_OFS_MATCH0 + 8'(4 * i), mv[i]);
    wr(`MPW_OFS_OUTCFG, 32'h0000_6a28);
    wr(`MPW_OFS_CTRL, 32'h9);
    meas(1, hi, per);
    chk(32'(hi), 32'd8, "single edge width");
    chk(32'(per), 32'd20, "period");
    meas(3, hi, per);
    chk(32'(hi), 32'd10, "negative pulse high");
    meas(5, hi, per);
    chk(32'(hi), 32'd12, "positive pulse high");
    chk(32'(per), 32'd20, "common rate");
    acc = '0;
    repeat (40) begin
      @(posedge mclk);
      acc = acc | pwm;
    end
    chk(32'({acc[6], acc[4]}), 32'h0, "constant low");
    // Low enable must freeze the running waveforms
    ce <= 1'b0;
    @(posedge mclk);
    acc = pwm;
    repeat (9) @(posedge mclk);
    chk(32'(pwm), 32'(acc), "frozen by enable");
    ce <= 1'b1;
    $display("test pwm done");
    // Unreleased value must not reach the comparator
    wr(`MPW_OFS_MATCH0 + 8'h04, 32'h6);
    meas(1, hi, per);
    meas(1, hi, per);
    chk(32'(hi), 32'd8, "unreleased width");
    rdc(`MPW_OFS_MATCH0 + 8'h04, 32'h6, "shadow value");
    wr(`MPW_OFS_LATCH, 32'h2);
    meas(1, hi, per);
    meas(1, hi, per);
    chk(32'(hi), 32'd14, "released width");
    chk(32'(per), 32'd20, "period kept");
    rdc(`MPW_OFS_LATCH, 32'h0, "release bit clears");
    $display("test release done");
    // Reset while waveforms run
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(32'({irq, pwm}), 32'h0, "outputs in reset");
    reset <= 1'b0;
    rdc(`MPW_OFS_CTRL, 32'h0, "control after reset");
    $display("test mid reset done");
    // Plain timer: match1 stops the count and interrupts
    wr(`MPW_OFS_MATCH0, 32'd100);
    wr(`MPW_OFS_MATCH0 + 8'h04, 32'd20);
    wr(`MPW_OFS_MATCHCTL, 32'h2b);
    wr(`MPW_OFS_MASK, 32'h2);
    wr(`MPW_OFS_OUTCFG, 32'h0000_6a28);
    wr(`MPW_OFS_CTRL, 32'h1);
    acc = '0;
    k = 0;
    while (irq !== 1'b1 && k < 300) begin
      @(posedge mclk);
      acc = acc | pwm;
      k++;
    end
    chk(32'(irq), 32'h1, "match interrupt");
    chk(32'(acc), 32'h0, "no waveform as timer");
    rdc(`MPW_OFS_CTRL, 32'h0, "run cleared by stop");
    // Stop lands one count past the match, then the count holds
    rdc(`MPW_OFS_COUNT, 32'd21, "counter stopped");
    rdc(`MPW_OFS_COUNT, 32'd21, "counter held");
    wr(`MPW_OFS_CTRL, 32'h2);
    rdc(`MPW_OFS_COUNT, 32'h0, "hold clears counter");
    rdc(`MPW_OFS_STATUS, 32'h2, "match flag");
    wr(`MPW_OFS_MASK, 32'h0);
    @(posedge mclk);
    chk(32'(irq), 32'h0, "masked");
    wr(`MPW_OFS_MASK, 32'h2);
    @(posedge mclk);
    chk(32'(irq), 32'h1, "unmasked");
    wr(`MPW_OFS_STATUS, 32'h2);
    @(posedge mclk);
    chk(32'(irq), 32'h0, "cleared");
    rdc(`MPW_OFS_STATUS, 32'h0, "flag cleared");
    $display("test timer done");
    test_done();
  end

endmodule : test_match_based_pwm_unit

`default_nettype wire
